// ---- rtl/lfap_top.v ----
// Functional notes
// [R1] Controller checks returned identify; non-controller relays it with request and poll bits.
// [R2] Host alone keeps written frames protocol-correct; nothing blocks bad ones.
// [R3] Controller compares returned command, auto-address and identify with sent frame.
// [R4] Controller sources ready-for-command after a clean command return, flags untouched.
// [R5] Controller: received ready-for-command ends handshake unchecked, sets output-ready.
// [R6] Talker checks returned data/end frames, updating mismatch and output-ready.
// [R7] With controller and talker clear, output-ready reads set always.
// [R8] Host masks output-ready interrupt while controller and talker are clear.
// [R9] Talker plus listener: every frame sets available and output-ready, no decoding; code still sets clear flag and relay latch.
// [R10] Mismatch flag sets only when the comparison finds an error.
// [R11] Addressed-command group follows controller, talker, listener and address match.
// [R12] Non-controller relays received request bit in data/end and identify frames.
// [R13] Relay latch sets when talker receives data/end with request bit set.
// [R14] Set relay latch forces request bit in next sourced data frame.
// [R15] Relay latch clears when any frame goes out with lowest control bit clear.
// [R16] Controller sends every data/end frame with request bit cleared.
// [R17] All three bits set: data/end 001 and 011 go out as 000 and 010.
// [R18] Analyzer non-controller: after one request frame, all frames get lowest bit set.
// [R19] Only master clear removes that forced request condition.
// [R20] Host issues master clear often when sending in that analyzer setting.
// [R21] Interface clear recognised only on an exact eleven-bit match.
// [R22] Ready-for-command recognised from the first six bits.
// [R23] Addressed-ready by five-bit prefix, auto-address by four-bit prefix; code has no four-bit match and takes auto-address as a remaining ready frame.
// [R24] Top bit zero is data/end; top two bits one is identify.
//
// Strobed register access and the register addresses were chosen for this implementation.
`timescale 1ns/1ps
`include "lfap_defs.vh"

module lfap_top (
  input  wire                     core_clk,
  input  wire                     rst,
  input  wire [`LFAP_ADDR_W-1:0]  reg_addr,
  input  wire [`LFAP_RD_W-1:0]    reg_wdata,
  input  wire                     reg_wr,
  input  wire                     reg_rd,
  output reg  [`LFAP_RD_W-1:0]    reg_rdata,
  input  wire                     rx_valid,
  input  wire [`LFAP_FRAME_W-1:0] rx_frame,
  output reg                      tx_valid,
  output reg  [`LFAP_FRAME_W-1:0] tx_frame
);

  // Control and configuration
  reg  [`LFAP_CTRL_W-1:0]  ctrl_r;
  reg  [`LFAP_LADR_W-1:0]  ladr_r;
  // Flags
  reg                      clr_flag_r;
  reg                      srq_flag_r;
  reg                      fav_flag_r;
  reg                      mis_flag_r;
  reg                      ora_flag_r;
  // Frame holding
  reg  [`LFAP_FRAME_W-1:0] rx_hold_r;
  reg  [`LFAP_FRAME_W-1:0] last_sent_r;
  reg  [`LFAP_FRAME_W-1:0] host_frame_r;
  reg                      host_pend_r;
  // Service request latches
  reg                      relay_r;
  reg                      force_r;

  wire sc;
  wire ca;
  wire ta;
  wire la;
  wire lsrq;
  wire master_clear;
  wire wr_ctrl;
  wire wr_flags;
  wire wr_tx;
  wire analyzer;
  wire rx_c0;
  wire err;
  wire c_doe;
  wire c_ifc;
  wire c_cmd;
  wire c_rfc;
  wire c_arg;
  wire c_rdy;
  wire c_idy;
  wire c_addressed_command_group;
  wire ora_view;
  wire [2:0] pp_pos;

  assign sc   = ctrl_r[`LFAP_CTRL_SC];
  assign ca   = ctrl_r[`LFAP_CTRL_CA];
  assign ta   = ctrl_r[`LFAP_CTRL_TA];
  assign la   = ctrl_r[`LFAP_CTRL_LA];
  assign lsrq = ctrl_r[`LFAP_CTRL_LSRQ];
  assign wr_ctrl  = reg_wr & (reg_addr == `LFAP_REG_CTRL);
  assign wr_flags = reg_wr & (reg_addr == `LFAP_REG_FLAGS);
  assign wr_tx    = reg_wr & (reg_addr == `LFAP_REG_TXFRAME);
  // Master clear is a self-clearing command bit
  assign master_clear = wr_ctrl & reg_wdata[`LFAP_CTRL_MCL];
  assign analyzer = ta & la;
  assign rx_c0 = rx_frame[`LFAP_C0_BIT];
  assign err = (rx_frame != last_sent_r); // [R3]
  assign pp_pos = ladr_r[`LFAP_LADR_PPOS_LO+2:`LFAP_LADR_PPOS_LO];
  // Output-ready shows set while neither controller nor talker
  assign ora_view = ora_flag_r | (~ca & ~ta); // [R7]

  lfap_classify u_classify (
    .frame    (rx_frame),
    .loop_adr (ladr_r[4:0]),
    .ca       (ca),
    .ta       (ta),
    .la       (la),
    .is_doe   (c_doe),
    .is_ifc   (c_ifc),
    .is_cmd   (c_cmd),
    .is_rfc   (c_rfc),
    .is_arg   (c_arg),
    .is_rdy   (c_rdy),
    .is_idy   (c_idy),
    .is_addressed_command_group  (c_addressed_command_group)
  );

  // Received-frame decisions
  reg clr_set;
  reg srq_set;
  reg fav_set;
  reg mis_set;
  reg ora_set;
  reg load;
  reg rtx;
  reg ready_for_command_frame;
  reg relay_set;

  always @* begin
    clr_set   = 1'b0;
    srq_set   = 1'b0;
    fav_set   = 1'b0;
    mis_set   = 1'b0;
    ora_set   = 1'b0;
    load      = 1'b0;
    rtx       = 1'b0;
    ready_for_command_frame       = 1'b0;
    relay_set = 1'b0;
    if (rx_valid) begin
      if (c_ifc) begin
        clr_set = 1'b1; // [R21]
      end
      if (ca & rx_c0 & (c_doe | c_idy)) begin
        srq_set = 1'b1;
      end
      if (ta & c_doe & rx_c0) begin
        relay_set = 1'b1; // [R13]
      end
      if (analyzer) begin
        fav_set = 1'b1; // [R9]
        ora_set = 1'b1; // [R9]
        load    = 1'b1; // [R9]
      end else if (c_doe) begin
        if (la) begin
          fav_set = 1'b1;
          load    = 1'b1;
          ora_set = ca;
        end else if (ta) begin
          ora_set = 1'b1; // [R6]
          if (err) begin
            mis_set = 1'b1; // [R10]
            load    = 1'b1;
          end
        end else begin
          rtx = 1'b1;
        end
      end else if (c_ifc) begin
        if (!ca) begin
          rtx = 1'b1;
        end else if (sc) begin
          if (err) begin
            mis_set = 1'b1; // [R10]
            ora_set = 1'b1;
            load    = 1'b1;
          end else begin
            ready_for_command_frame = 1'b1;
          end
        end
      end else if (c_cmd) begin
        if (ca) begin
          if (err) begin
            mis_set = 1'b1; // [R3]
            ora_set = 1'b1; // [R10]
            load    = 1'b1;
          end else begin
            ready_for_command_frame = 1'b1; // [R4]
          end
        end else begin
          rtx = 1'b1;
          if (c_addressed_command_group) begin
            fav_set = 1'b1; // [R11]
            load    = 1'b1;
          end
        end
      end else if (c_rfc) begin
        if (ca) begin
          ora_set = 1'b1; // [R5]
        end else begin
          rtx = 1'b1;
        end
      end else if (c_arg) begin
        if (ca | ta | la) begin
          fav_set = 1'b1;
          ora_set = 1'b1;
          load    = 1'b1;
        end else begin
          rtx = 1'b1;
        end
      end else if (c_rdy) begin
        if (ca) begin
          ora_set = 1'b1;
          if (err) begin
            mis_set = 1'b1; // [R3]
            load    = 1'b1;
          end
        end else begin
          fav_set = 1'b1;
          ora_set = 1'b1;
          load    = 1'b1;
        end
      end else begin
        if (ca) begin
          ora_set = 1'b1; // [R1]
          if (err) begin
            mis_set = 1'b1; // [R10]
            load    = 1'b1;
          end
        end else begin
          rtx = 1'b1; // [R1]
        end
      end
    end
  end

  // Outgoing frame assembly
  reg  [`LFAP_FRAME_W-1:0] relay_frame;
  reg  [`LFAP_FRAME_W-1:0] out_frame;
  reg                      sending;
  reg                      host_go;
  reg                      out_doe;

  always @* begin
    relay_frame = rx_frame;
    if (!ca & (c_doe | c_idy)) begin
      relay_frame[`LFAP_C0_BIT] = rx_c0 | lsrq; // [R12]
    end
    if (!ca & c_idy) begin
      relay_frame[pp_pos] = rx_frame[pp_pos] | ladr_r[`LFAP_LADR_PPR]; // [R1]
    end
    host_go = host_pend_r & ~rtx & ~ready_for_command_frame;
    sending = rtx | ready_for_command_frame | host_pend_r;
    if (rtx) begin
      out_frame = relay_frame;
    end else if (ready_for_command_frame) begin
      out_frame = `LFAP_RFC_FRAME; // [R4]
    end else begin
      // Host frames go out unchecked
      out_frame = host_frame_r; // [R2]
      if (relay_r & ~host_frame_r[10]) begin
        out_frame[`LFAP_C0_BIT] = 1'b1; // [R14]
      end
    end
    out_doe = ~out_frame[10];
    if (ca & out_doe) begin
      out_frame[`LFAP_C0_BIT] = 1'b0; // [R16] [R17]
    end
    if (force_r & ~ca & analyzer) begin
      out_frame[`LFAP_C0_BIT] = 1'b1; // [R18]
    end
  end

  // Registers and flags
  always @(posedge core_clk) begin
    if (rst) begin
      ctrl_r       <= `LFAP_CTRL_RST;
      ladr_r       <= `LFAP_LADR_RST;
      clr_flag_r   <= 1'b0;
      srq_flag_r   <= 1'b0;
      fav_flag_r   <= 1'b0;
      mis_flag_r   <= 1'b0;
      ora_flag_r   <= 1'b0;
      rx_hold_r    <= {`LFAP_FRAME_W{1'b0}};
      last_sent_r  <= {`LFAP_FRAME_W{1'b0}};
      host_frame_r <= {`LFAP_FRAME_W{1'b0}};
      host_pend_r  <= 1'b0;
      relay_r      <= 1'b0;
      force_r      <= 1'b0;
      tx_valid     <= 1'b0;
      tx_frame     <= {`LFAP_FRAME_W{1'b0}};
    end else begin
      if (wr_ctrl) begin
        ctrl_r <= reg_wdata[`LFAP_CTRL_W-1:0];
      end
      if (reg_wr & (reg_addr == `LFAP_REG_LOOPADR)) begin
        ladr_r <= reg_wdata[`LFAP_LADR_W-1:0];
      end
      if (master_clear) begin
        clr_flag_r  <= 1'b0;
        srq_flag_r  <= 1'b0;
        fav_flag_r  <= 1'b0;
        mis_flag_r  <= 1'b0;
        ora_flag_r  <= 1'b0;
        host_pend_r <= 1'b0;
        relay_r     <= 1'b0;
        force_r     <= 1'b0; // [R19]
      end else begin
        // Write one to clear; a set in the same cycle wins
        clr_flag_r <= (clr_flag_r & ~(wr_flags & reg_wdata[`LFAP_FLG_CLR])) | clr_set;
        srq_flag_r <= (srq_flag_r & ~(wr_flags & reg_wdata[`LFAP_FLG_SRQ])) | srq_set;
        fav_flag_r <= (fav_flag_r & ~(wr_flags & reg_wdata[`LFAP_FLG_FAV])) | fav_set;
        mis_flag_r <= (mis_flag_r & ~(wr_flags & reg_wdata[`LFAP_FLG_MIS])) | mis_set;
        ora_flag_r <= (ora_flag_r & ~(wr_flags & reg_wdata[`LFAP_FLG_ORA]) & ~wr_tx)
                      | ora_set;
        if (wr_tx) begin
          host_pend_r <= 1'b1;
        end else if (host_go) begin
          host_pend_r <= 1'b0;
        end
        if (relay_set) begin
          relay_r <= 1'b1; // [R13]
        end else if (sending & ~out_frame[`LFAP_C0_BIT]) begin
          relay_r <= 1'b0; // [R15]
        end
        if (sending & out_frame[`LFAP_C0_BIT] & ~ca & analyzer) begin
          force_r <= 1'b1; // [R18]
        end
      end
      if (wr_tx) begin
        host_frame_r <= reg_wdata[`LFAP_FRAME_W-1:0];
      end
      if (load) begin
        rx_hold_r <= rx_frame;
      end
      tx_valid <= sending & ~master_clear;
      if (sending) begin
        tx_frame    <= out_frame;
        last_sent_r <= out_frame;
      end
    end
  end

  // Register read port, data in the cycle after the strobe
  always @(posedge core_clk) begin
    if (rst) begin
      reg_rdata <= {`LFAP_RD_W{1'b0}};
    end else if (reg_rd) begin
      case (reg_addr)
        `LFAP_REG_CTRL: begin
          reg_rdata <= {11'h000, ctrl_r};
        end
        `LFAP_REG_FLAGS: begin
          reg_rdata <= {9'h000, force_r, relay_r, ora_view, mis_flag_r,
                        fav_flag_r, srq_flag_r, clr_flag_r};
        end
        `LFAP_REG_RXFRAME: begin
          reg_rdata <= {5'h00, rx_hold_r};
        end
        `LFAP_REG_TXFRAME: begin
          reg_rdata <= {5'h00, last_sent_r};
        end
        `LFAP_REG_LOOPADR: begin
          reg_rdata <= {7'h00, ladr_r};
        end
        default: begin
          reg_rdata <= {`LFAP_RD_W{1'b0}};
        end
      endcase
    end else begin
      reg_rdata <= {`LFAP_RD_W{1'b0}};
    end
  end

endmodule // lfap_top

// ---- rtl/lfap_defs.vh ----
`ifndef LFAP_DEFS_VH
`define LFAP_DEFS_VH

// Frame layout: control bits C2..C0 on top, eight data bits below
`define LFAP_FRAME_W      11
`define LFAP_DATA_W       8
`define LFAP_C0_BIT       8
`define LFAP_RD_W         16
`define LFAP_ADDR_W       3

// Register offsets
`define LFAP_REG_CTRL     3'h0
`define LFAP_REG_FLAGS    3'h1
`define LFAP_REG_RXFRAME  3'h2
`define LFAP_REG_TXFRAME  3'h3
`define LFAP_REG_LOOPADR  3'h4

// Control register fields
`define LFAP_CTRL_SC      0
`define LFAP_CTRL_CA      1
`define LFAP_CTRL_TA      2
`define LFAP_CTRL_LA      3
`define LFAP_CTRL_LSRQ    4
`define LFAP_CTRL_MCL     5
`define LFAP_CTRL_W       5
`define LFAP_CTRL_RST     5'h00

// Flag register fields
`define LFAP_FLG_CLR      0
`define LFAP_FLG_SRQ      1
`define LFAP_FLG_FAV      2
`define LFAP_FLG_MIS      3
`define LFAP_FLG_ORA      4
`define LFAP_FLG_RELAY    5
`define LFAP_FLG_FORCE    6
`define LFAP_FLG_W        5

// Loop address register: [4:0] address, [7:5] poll bit position, [8] poll response
`define LFAP_LADR_W       9
`define LFAP_LADR_RST     9'h000
`define LFAP_LADR_PPOS_LO 5
`define LFAP_LADR_PPR     8

// Frame patterns
`define LFAP_IFC_PAT      11'h490
`define LFAP_RFC_PAT      6'h28
`define LFAP_RFC_FRAME    11'h500
`define LFAP_ARG_PAT      5'h15
`define LFAP_AAG_PAT      4'hB
`define LFAP_CMD_CTL      3'h4
`define LFAP_RDY_CTL      3'h5

// Command data classes in data bits [7:5]
`define LFAP_UCG_CLS      3'h0
`define LFAP_LAG_CLS      3'h1
`define LFAP_TAG_CLS      3'h2
`define LFAP_SAG_CLS      3'h3

`endif

// ---- rtl/lfap_classify.v ----
`timescale 1ns/1ps
`include "lfap_defs.vh"

module lfap_classify (
  input  wire [`LFAP_FRAME_W-1:0] frame,
  input  wire [4:0]               loop_adr,
  input  wire                     ca,
  input  wire                     ta,
  input  wire                     la,
  output wire                     is_doe,
  output wire                     is_ifc,
  output wire                     is_cmd,
  output wire                     is_rfc,
  output wire                     is_arg,
  output wire                     is_rdy,
  output wire                     is_idy,
  output wire                     is_addressed_command_group
);

  wire [2:0] ctl;
  wire [2:0] cls;
  wire       adr_eq;

  assign ctl = frame[10:8];
  assign cls = frame[7:5];
  assign adr_eq = (frame[4:0] == loop_adr);

  // Data/end when top bit is zero, identify when top two bits are one
  assign is_doe = ~frame[10]; // [R24]
  assign is_idy = (frame[10:9] == 2'h3); // [R24]
  // Interface clear needs all eleven bits
  assign is_ifc = (frame == `LFAP_IFC_PAT); // [R21]
  assign is_cmd = (ctl == `LFAP_CMD_CTL) & ~is_ifc;
  assign is_rfc = (frame[10:5] == `LFAP_RFC_PAT); // [R22]
  assign is_arg = ~is_rfc & (frame[10:6] == `LFAP_ARG_PAT); // [R23]
  // Remaining ready frames, the auto-address prefix among them
  assign is_rdy = (ctl == `LFAP_RDY_CTL) & ~is_rfc & ~is_arg; // [R23]

  // Addressed-command group
  assign is_addressed_command_group = ~ca & is_cmd & (la | ta | (cls == `LFAP_UCG_CLS) | // [R11]
                   (cls == `LFAP_SAG_CLS) |
                   (((cls == `LFAP_TAG_CLS) | (cls == `LFAP_LAG_CLS)) & adr_eq));

endmodule // lfap_classify

// ---- test/lfap_top_assertions.sv ----
`timescale 1ns/1ps
`include "lfap_defs.vh"
module lfap_chk (
  input wire        core_clk,
  input wire        rst,
  input wire [2:0]  reg_addr,
  input wire [15:0] reg_wdata,
  input wire        reg_wr,
  input wire        reg_rd,
  input wire [15:0] reg_rdata,
  input wire        rx_valid,
  input wire [10:0] rx_frame,
  input wire        tx_valid,
  input wire [10:0] tx_frame
);
  reg  [4:0] ctl_r;
  wire       ca = ctl_r[1];
  wire       ta = ctl_r[2];
  wire       la = ctl_r[3];
  wire       tx_wr = reg_wr && reg_addr == `LFAP_REG_TXFRAME;
  // Shadow of the control register
  always @(posedge core_clk) begin
    if (rst)
      ctl_r <= 5'h00;
    else if (reg_wr && reg_addr == `LFAP_REG_CTRL)
      ctl_r <= reg_wdata[4:0];
  end
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);
  sequence s_cmd_back;
    rx_valid && ca && !(ta && la) && rx_frame[10:8] == `LFAP_CMD_CTL &&
      rx_frame == tx_frame && rx_frame != `LFAP_IFC_PAT;
  endsequence
  sequence s_rfc_out;
    tx_valid && tx_frame == `LFAP_RFC_FRAME;
  endsequence
  property p_rfc_src;
    s_cmd_back |=> s_rfc_out;
  endproperty
  a_rfc_src: assert property (p_rfc_src) else $error("no ready frame");
  property p_idle_rd;
    !reg_rd |=> reg_rdata == 16'h0000;
  endproperty
  a_idle_rd: assert property (p_idle_rd) else $error("read data not idle");
  property p_unmap;
    reg_rd && reg_addr > `LFAP_REG_LOOPADR |=> reg_rdata == 16'h0000;
  endproperty
  a_unmap: assert property (p_unmap) else $error("unmapped read not zero");
  property p_ora_hi;
    reg_rd && reg_addr == `LFAP_REG_FLAGS && !ca && !ta |=> reg_rdata[`LFAP_FLG_ORA];
  endproperty
  a_ora_hi: assert property (p_ora_hi) else $error("output ready low");
  property p_doe_srq;
    tx_valid && ca && $past(ca) && !tx_frame[10] |-> !tx_frame[`LFAP_C0_BIT];
  endproperty
  a_doe_srq: assert property (p_doe_srq) else $error("request bit sent");
  property p_relay;
    rx_valid && !ca && !ta && !la && !rx_frame[10] && rx_frame[8]
      |=> tx_valid && tx_frame == $past(rx_frame);
  endproperty
  a_relay: assert property (p_relay) else $error("relay frame changed");
  property p_idy;
    rx_valid && !ca && !(ta && la) && !ctl_r[4] && rx_frame[10:9] == 2'b11
      |=> tx_valid && tx_frame[10:9] == 2'b11;
  endproperty
  a_idy: assert property (p_idy) else $error("identify not relayed");
  property p_ifc;
    rx_valid && !ca && !(ta && la) && rx_frame == `LFAP_IFC_PAT
      |=> tx_valid && tx_frame == `LFAP_IFC_PAT;
  endproperty
  a_ifc: assert property (p_ifc) else $error("clear frame not relayed");
  property p_anlz;
    rx_valid && ta && la && !tx_wr && !$past(tx_wr) |=> !tx_valid;
  endproperty
  a_anlz: assert property (p_anlz) else $error("analyzer relayed");
endmodule // lfap_chk
bind lfap_top lfap_chk i_chk (.core_clk(core_clk), .rst(rst), .reg_addr(reg_addr),
  .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
  .rx_valid(rx_valid), .rx_frame(rx_frame), .tx_valid(tx_valid), .tx_frame(tx_frame));

// ---- test/lfap_loop_peer.sv ----
`timescale 1ns/1ps
module lfap_loop_peer (
  input  wire        core_clk,
  input  wire        tx_valid,
  input  wire [10:0] tx_frame,
  output reg         rx_valid,
  output reg  [10:0] rx_frame
);
  reg        got_valid;
  reg [10:0] got_frame;
  initial begin
    rx_valid = 1'b0;
    rx_frame = 11'h7FF;
    got_valid = 1'b0;
    got_frame = 11'h000;
  end
  // Following device takes each frame sent on
  always @(posedge core_clk) begin
    got_valid <= (tx_valid === 1'b1);
    if (tx_valid === 1'b1)
      got_frame <= tx_frame;
  end
  // Preceding device hands one frame; line shows the inverse once released
  task send(input [10:0] f);
    begin
      rx_valid <= 1'b1;
      rx_frame <= f;
      @(posedge core_clk);
      rx_valid <= 1'b0;
      rx_frame <= ~f;
    end
  endtask
endmodule // lfap_loop_peer

// ---- test/testbench.sv ----
`timescale 1ns/1ps
module testbench;
  reg         core_clk;
  reg         rst;
  reg  [2:0]  reg_addr;
  reg  [15:0] reg_wdata;
  reg         reg_wr;
  reg         reg_rd;
  wire [15:0] reg_rdata;
  wire        rx_valid;
  wire [10:0] rx_frame;
  wire        tx_valid;
  wire [10:0] tx_frame;
  integer     fails;
  integer     n_tests;
  reg  [15:0] got;
  lfap_top i_dut (.core_clk(core_clk), .rst(rst), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .rx_valid(rx_valid), .rx_frame(rx_frame), .tx_valid(tx_valid), .tx_frame(tx_frame));
  lfap_loop_peer i_peer (.core_clk(core_clk), .tx_valid(tx_valid), .tx_frame(tx_frame),
    .rx_valid(rx_valid), .rx_frame(rx_frame));
  always #25 core_clk = ~core_clk;
  task stop_test;
    begin
      $display("comparisons %0d mismatches %0d", n_tests, fails);
      if (fails == 0 && n_tests > 0)
        $display("NO MISMATCHES");
      else
        $display("MISMATCHES SEEN");
      $finish;
    end
  endtask
  task chk(input [15:0] g, input [15:0] e);
    begin
      n_tests = n_tests + 1;
      if (g !== e) begin
        fails = fails + 1;
        $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e);
      end
    end
  endtask
  task wr(input [2:0] a, input [15:0] d);
    begin
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'b1;
      @(posedge core_clk);
      reg_wr <= 1'b0;
      @(posedge core_clk);
    end
  endtask
  task rd_chk(input [2:0] a, input [15:0] e);
    begin
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge core_clk);
      reg_rd <= 1'b0;
      @(posedge core_clk);
      chk(reg_rdata, e);
    end
  endtask
  // First frame taken by the following device within four edges; FFFF when none
  task wait_tx(output [15:0] g);
    integer k;
    begin
      g = 16'hFFFF;
      for (k = 0; k < 4; k = k + 1) begin
        @(posedge core_clk);
        if (i_peer.got_valid === 1'b1 && g === 16'hFFFF)
          g = {5'h00, i_peer.got_frame};
      end
    end
  endtask
  task rx_tx(input [10:0] f, input [15:0] e);
    begin
      i_peer.send(f);
      wait_tx(got);
      chk(got, e);
    end
  endtask
  task host_tx(input [10:0] f, input [15:0] e);
    begin
      wr(3'h3, {5'h00, f});
      wait_tx(got);
      chk(got, e);
    end
  endtask
  task t_reset;
    begin
      chk({15'h0000, tx_valid}, 16'h0000);
      rd_chk(3'h1, 16'h0010);
      rd_chk(3'h5, 16'h0000);
      rd_chk(3'h0, 16'h0000);
    end
  endtask
  task t_retx;
    begin
      rx_tx(11'h112, 16'h0112);
      wr(3'h0, 16'h0010);
      rx_tx(11'h033, 16'h0133);
      rx_tx(11'h490, 16'h0490);
      rd_chk(3'h1, 16'h0011);
      wr(3'h1, 16'h001F);
      rx_tx(11'h491, 16'h0491);
      rd_chk(3'h1, 16'h0010);
      rx_tx(11'h414, 16'h0414);
      rd_chk(3'h1, 16'h0014);
      rd_chk(3'h2, 16'h0414);
      wr(3'h0, 16'h0000);
      wr(3'h4, 16'h0160);
      rx_tx(11'h600, 16'h0608);
    end
  endtask
  task t_ctrl;
    begin
      wr(3'h0, 16'h0003);
      wr(3'h1, 16'h001F);
      host_tx(11'h420, 16'h0420);
      rx_tx(11'h420, 16'h0500);
      rd_chk(3'h1, 16'h0000);
      rx_tx(11'h500, 16'hFFFF);
      rd_chk(3'h1, 16'h0010);
      host_tx(11'h421, 16'h0421);
      rx_tx(11'h425, 16'hFFFF);
      rd_chk(3'h1, 16'h0018);
      host_tx(11'h1AA, 16'h00AA);
    end
  endtask
  task t_relay;
    begin
      wr(3'h0, 16'h0004);
      wr(3'h1, 16'h001F);
      rx_tx(11'h133, 16'hFFFF);
      rd_chk(3'h1, 16'h0038);
      host_tx(11'h044, 16'h0144);
      wr(3'h1, 16'h001F);
      host_tx(11'h420, 16'h0420);
      rd_chk(3'h1, 16'h0000);
    end
  endtask
  task t_anlz;
    begin
      wr(3'h0, 16'h002C);
      rx_tx(11'h420, 16'hFFFF);
      rd_chk(3'h1, 16'h0014);
      rd_chk(3'h2, 16'h0420);
      host_tx(11'h155, 16'h0155);
      host_tx(11'h420, 16'h0520);
      wr(3'h0, 16'h002C);
      host_tx(11'h420, 16'h0420);
      wr(3'h0, 16'h000E);
      host_tx(11'h1AA, 16'h00AA);
      host_tx(11'h355, 16'h0255);
    end
  endtask
  initial begin
    core_clk = 1'b0;
    rst = 1'b1;
    reg_addr = 3'h0;
    reg_wdata = 16'h0000;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    fails = 0;
    n_tests = 0;
    repeat (4) @(posedge core_clk);
    rst <= 1'b0;
    @(posedge core_clk);
    t_reset;
    t_retx;
    t_ctrl;
    t_relay;
    t_anlz;
    stop_test;
  end
  initial begin
    #(5000 * 50);
    fails = fails + 1;
    stop_test;
  end
endmodule // testbench
